//--- hdl/stbt_pkg.sv
package stbt_pkg;

  // Widths of the transceiver and the test registers
  localparam int HALF_W = 9;
  localparam int DATA_W = 18;
  localparam int CTRL_PINS = 12;
  localparam int BSR_W = 48;
  localparam int IR_W = 8;
  localparam int CTL_W = 3;
  localparam int ID_W = 32;
  localparam int PIN_W = 51;
  localparam int LEN_W = 6;

  // Boundary cell positions, one cell per pin
  localparam int CELL_A_LSB = 0;
  localparam int CELL_B_LSB = 18;
  localparam int CELL_LE_LSB = 36;
  localparam int CELL_CLK_LSB = 40;
  localparam int CELL_OE_LSB = 44;

  // Positions of the test port pins in the synchronised pin vector
  localparam int PIN_TCK = 48;
  localparam int PIN_TMS = 49;
  localparam int PIN_TDI = 50;

  // Synchroniser reset: enables, mode select and serial input read high
  localparam logic [PIN_W-1:0] PIN_RESET = 51'h6_F000_0000_0000;

  // Instruction opcodes, even parity
  localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
  localparam logic [IR_W-1:0] OP_BYPASS = 8'hFF;
  localparam logic [IR_W-1:0] OP_SAMPLE = 8'h82;
  localparam logic [IR_W-1:0] OP_IDCODE = 8'h81;
  localparam logic [IR_W-1:0] OP_HIGHZ = 8'h06;
  localparam logic [IR_W-1:0] OP_CLAMP = 8'h84;
  localparam logic [IR_W-1:0] OP_RUNTEST = 8'h09;
  localparam logic [IR_W-1:0] OP_READBACK = 8'h03;
  localparam logic [IR_W-1:0] OP_SCANCTL = 8'h8E;

  // Reset and capture values
  localparam logic [IR_W-1:0] IR_RESET = 8'h81;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [CTL_W-1:0] CTL_RESET = 3'h2;
  localparam logic [3:0] OE_CELL_RESET = 4'hF;

  // Boundary-control test operations
  localparam logic [CTL_W-1:0] CTL_TOGGLE = 3'h1;
  localparam logic [CTL_W-1:0] CTL_SIGNATURE = 3'h2;
  localparam logic [CTL_W-1:0] CTL_SIG_COUNT = 3'h3;
  localparam logic [CTL_W-1:0] CTL_RANDOM = 3'h4;

  // Register lengths in the scan path
  localparam logic [LEN_W-1:0] LEN_BSR = 6'h30;
  localparam logic [LEN_W-1:0] LEN_ID = 6'h20;
  localparam logic [LEN_W-1:0] LEN_CTL = 6'h03;
  localparam logic [LEN_W-1:0] LEN_BYP = 6'h01;

  // Feedback tap of the 18-bit pattern and signature register
  localparam int LFSR_TAP = 10;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } stbt_tap_state_t;

endpackage

//--- hdl/stbt_fifo.sv
`timescale 1ns/1ps
module stbt_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("stbt_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Full when pointers differ only in the wrap bit
  assign in_ready = ~((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // stbt_fifo

//--- hdl/stbt_core.sv
// Operation
// - A-to-B latch enable high: B follows A transparently.
// - Latch enable low, clock steady: B holds the stored A value.
// - Latch enable low: A stored on each rising A-to-B clock edge.
// - Active-low A-to-B enable drives B outputs; high leaves them undriven.
// - B-to-A path mirrors A-to-B with its own controls.
// - Two independent 9-bit halves, usable together as 18 bits.
// - Test port activity in normal mode leaves data paths untouched.
// - Test mode suppresses normal paths; boundary cells control all pins.
// - Test inputs sampled on rising test clock; outputs change on falling. Run-test steps in idle change driven pins on rising.
// - Test controller state advances only by the mode select level.
// - Serial input feeds selected register; serial output shows its outgoing bit.
// - Unconnected mode select, serial input and output enables read high.
// - Eight-bit instruction register loaded through the instruction scan path.
// - Boundary 48, control 3, bypass 1 and identification 32-bit registers.
// - Exactly one boundary cell per pin.
// - Signature compression of inputs, pseudo-random patterns on outputs; random operation 100 holds the input cells, no signature.
// - Signature compression combined with binary up-count on outputs.
// - Mandatory instructions plus clamp and high-impedance instructions.
// - Normal mode supports pin snapshots and boundary cell self test.
// - Test-logic reset loads instruction 10000001, selecting identification.
// - Test-logic reset loads boundary-control value 010, signature operation.
// - Test-logic reset sets the four output-enable cells to one.
// - Instruction capture loads fixed pattern 10000001.
`timescale 1ns/1ps
module stbt_core #(
  parameter logic [stbt_pkg::ID_W-1:0] ID_VALUE = 32'h0A5A_0001, // Arbitrary identification value
  parameter int SNAP_DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // A bus
  input wire logic [stbt_pkg::DATA_W-1:0] port_a_in,
  output logic [stbt_pkg::DATA_W-1:0] port_a_out,
  output logic [1:0] port_a_oe,
  // B bus
  input wire logic [stbt_pkg::DATA_W-1:0] port_b_in,
  output logic [stbt_pkg::DATA_W-1:0] port_b_out,
  output logic [1:0] port_b_oe,
  // Direction controls, one bit per half
  input wire logic [1:0] a_to_b_output_enable_n,
  input wire logic [1:0] b_to_a_output_enable_n,
  input wire logic [1:0] a_to_b_latch_enable,
  input wire logic [1:0] b_to_a_latch_enable,
  input wire logic [1:0] a_to_b_clock,
  input wire logic [1:0] b_to_a_clock,
  // Test access port
  input wire logic test_clock,
  input wire logic test_mode_select,
  input wire logic test_data_in,
  output logic test_data_out,
  output logic test_data_out_oe,
  // Pin snapshot stream
  output logic snap_valid,
  input wire logic snap_ready,
  output logic [stbt_pkg::BSR_W-1:0] snap_data,
  output logic snap_room,
  // Status
  output logic test_mode
);
  import stbt_pkg::*;

  if (ID_VALUE[0] != 1'b1) begin : g_bad_id
    $error("stbt_core identification value must end in one");
  end

  // Pin synchronisers
  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_sync_r;
  logic tck_prev_r;
  wire [3:0] oe_raw = {a_to_b_output_enable_n[0], b_to_a_output_enable_n[0],
                       a_to_b_output_enable_n[1], b_to_a_output_enable_n[1]};
  wire [3:0] clk_raw = {a_to_b_clock[0], b_to_a_clock[0], a_to_b_clock[1], b_to_a_clock[1]};
  wire [3:0] le_raw = {a_to_b_latch_enable[0], b_to_a_latch_enable[0],
                       a_to_b_latch_enable[1], b_to_a_latch_enable[1]};
  wire [PIN_W-1:0] pin_raw = {test_data_in, test_mode_select, test_clock, oe_raw, clk_raw, le_raw,
                              port_b_in, port_a_in};

  // Two flops per pin; idle level of floating inputs is high
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_meta_r <= PIN_RESET;
      pin_sync_r <= PIN_RESET;
      tck_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
      tck_prev_r <= pin_sync_r[PIN_TCK];
    end
  end

  // Test clock edges and sampled test inputs
  wire tck_rise = pin_sync_r[PIN_TCK] & ~tck_prev_r;
  wire tck_fall = ~pin_sync_r[PIN_TCK] & tck_prev_r;
  wire tms = pin_sync_r[PIN_TMS];
  wire tdi = pin_sync_r[PIN_TDI];
  wire [BSR_W-1:0] pins_now = pin_sync_r[BSR_W-1:0];

  // Test controller
  stbt_tap_state_t tap_r;
  stbt_tap_state_t tap_nxt;

  // Next state from the mode select level alone
  always_comb begin
    case (tap_r)
      TAP_RESET: tap_nxt = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_nxt = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_nxt = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_nxt = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_nxt = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      default: tap_nxt = TAP_RESET;
    endcase
  end

  // State register, advanced on rising test clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tap_r <= TAP_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  // Instruction decode
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_shift_r;
  logic [CTL_W-1:0] ctl_r;
  logic [BSR_W-1:0] bsr_upd_r;
  logic [BSR_W-1:0] dr_shift_r;
  wire is_extest = ir_r == OP_EXTEST;
  wire is_sample = ir_r == OP_SAMPLE;
  wire is_idcode = ir_r == OP_IDCODE;
  wire is_highz = ir_r == OP_HIGHZ;
  wire is_clamp = ir_r == OP_CLAMP;
  wire is_runtest = ir_r == OP_RUNTEST;
  wire is_readback = ir_r == OP_READBACK;
  wire is_scanctl = ir_r == OP_SCANCTL;
  wire sel_bsr = is_extest | is_sample | is_runtest | is_readback;
  wire sel_ctl = is_scanctl;
  wire sel_id = is_idcode;
  // Unknown opcodes fall back to the bypass register
  wire sel_byp = ~(sel_bsr | sel_ctl | sel_id);
  assign test_mode = is_extest | is_highz | is_clamp | is_runtest;

  // Scan length of the selected data register
  wire [LEN_W-1:0] dr_len = sel_bsr ? LEN_BSR : (sel_id ? LEN_ID : (sel_ctl ? LEN_CTL : LEN_BYP));

  // Capture sources: pins for snapshot, cell latches for self test
  wire [BSR_W-1:0] cap_bsr = (is_readback | is_runtest) ? bsr_upd_r : pins_now;
  wire [BSR_W-1:0] dr_capture = sel_bsr ? cap_bsr :
                                sel_id ? {{(BSR_W-ID_W){1'b0}}, ID_VALUE} :
                                sel_ctl ? {{(BSR_W-CTL_W){1'b0}}, ctl_r} : {BSR_W{1'b0}};

  // Variable-length shift, serial input enters at the selected length
  logic [BSR_W-1:0] dr_shift_nxt;
  for (genvar i = 0; i < BSR_W; i++) begin : g_shift
    localparam logic [LEN_W-1:0] POS = LEN_W'(i + 1);
    if (i == BSR_W - 1) begin : g_top
      assign dr_shift_nxt[i] = (POS == dr_len) ? tdi : 1'b0;
    end else begin : g_mid
      assign dr_shift_nxt[i] = (POS == dr_len) ? tdi : ((POS < dr_len) ? dr_shift_r[i+1] : 1'b0);
    end
  end

  // Capture and shift on rising edges
  wire cap_dr = tck_rise && tap_r == TAP_CAP_DR;
  wire cap_ir = tck_rise && tap_r == TAP_CAP_IR;
  wire shift_dr = tck_rise && tap_r == TAP_SHIFT_DR;
  wire shift_ir = tck_rise && tap_r == TAP_SHIFT_IR;
  wire upd_dr = tck_fall && tap_r == TAP_UPD_DR;
  wire upd_ir = tck_fall && tap_r == TAP_UPD_IR;
  wire in_reset = tap_r == TAP_RESET;

  // Data shift register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dr_shift_r <= '0;
    end else if (cap_dr) begin
      dr_shift_r <= dr_capture;
    end else if (shift_dr) begin
      dr_shift_r <= dr_shift_nxt;
    end
  end

  // Instruction shift register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ir_shift_r <= IR_CAPTURE;
    end else if (cap_ir) begin
      ir_shift_r <= IR_CAPTURE;
    end else if (shift_ir) begin
      ir_shift_r <= {tdi, ir_shift_r[IR_W-1:1]};
    end
  end

  // Instruction and control registers, updated on falling edges
  always_ff @(posedge clock) begin
    if (!reset_n || in_reset) begin
      ir_r <= IR_RESET;
      ctl_r <= CTL_RESET;
    end else begin
      if (upd_ir) ir_r <= ir_shift_r;
      if (upd_dr && sel_ctl) ctl_r <= dr_shift_r[CTL_W-1:0];
    end
  end

  // Which side holds the observed inputs during test operations
  wire ab_dir = ~bsr_upd_r[CELL_OE_LSB+3];
  wire [DATA_W-1:0] obs_cells = ab_dir ? bsr_upd_r[CELL_A_LSB +: DATA_W] : bsr_upd_r[CELL_B_LSB +: DATA_W];
  wire [DATA_W-1:0] drv_cells = ab_dir ? bsr_upd_r[CELL_B_LSB +: DATA_W] : bsr_upd_r[CELL_A_LSB +: DATA_W];
  wire [DATA_W-1:0] obs_pins = ab_dir ? pins_now[CELL_A_LSB +: DATA_W] : pins_now[CELL_B_LSB +: DATA_W];

  // Signature, pattern and count steps
  wire [DATA_W-1:0] sig_step = {obs_cells[DATA_W-2:0], obs_cells[DATA_W-1] ^ obs_cells[LFSR_TAP]} ^ obs_pins;
  wire [DATA_W-1:0] random_pattern_generation_step = {drv_cells[DATA_W-2:0], ~(drv_cells[DATA_W-1] ^ drv_cells[LFSR_TAP])};
  wire [DATA_W-1:0] count_step = drv_cells + 1'b1;
  logic [DATA_W-1:0] obs_nxt;
  logic [DATA_W-1:0] drv_nxt;

  // Boundary-control operation select
  always_comb begin
    case (ctl_r)
      CTL_TOGGLE: begin
        obs_nxt = obs_pins;
        drv_nxt = ~drv_cells;
      end
      CTL_SIGNATURE: begin
        obs_nxt = sig_step;
        drv_nxt = drv_cells;
      end
      CTL_SIG_COUNT: begin
        obs_nxt = sig_step;
        drv_nxt = count_step;
      end
      CTL_RANDOM: begin
        obs_nxt = obs_cells;
        drv_nxt = random_pattern_generation_step;
      end
      default: begin
        obs_nxt = obs_cells;
        drv_nxt = drv_cells;
      end
    endcase
  end

  wire run_step = tck_rise && is_runtest && tap_r == TAP_IDLE;
  wire [BSR_W-1:0] bsr_run = ab_dir ? {bsr_upd_r[BSR_W-1:CELL_LE_LSB], drv_nxt, obs_nxt}
                                    : {bsr_upd_r[BSR_W-1:CELL_LE_LSB], obs_nxt, drv_nxt};

  // Boundary cell latches, one cell per pin
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bsr_upd_r <= {OE_CELL_RESET, {(BSR_W-4){1'b0}}};
    end else if (in_reset) begin
      bsr_upd_r[BSR_W-1:CELL_OE_LSB] <= OE_CELL_RESET;
    end else if (upd_dr && (is_extest || is_sample)) begin
      bsr_upd_r <= dr_shift_r;
    end else if (run_step) begin
      bsr_upd_r <= bsr_run;
    end
  end

  // Serial output, changed on falling edges only
  wire in_shift = tap_r == TAP_SHIFT_DR || tap_r == TAP_SHIFT_IR;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      test_data_out <= 1'b0;
      test_data_out_oe <= 1'b0;
    end else if (tck_fall) begin
      test_data_out <= (tap_r == TAP_SHIFT_IR) ? ir_shift_r[0] : dr_shift_r[0];
      test_data_out_oe <= in_shift;
    end
  end

  // Normal transceiver storage, per half and direction
  logic [DATA_W-1:0] store_ab_r;
  logic [DATA_W-1:0] store_ba_r;
  logic [3:0] clk_prev_r;
  logic [1:0] oe_ab_norm;
  logic [1:0] oe_ba_norm;
  wire [3:0] clk_now = pins_now[CELL_CLK_LSB +: 4];
  wire [3:0] le_now = pins_now[CELL_LE_LSB +: 4];
  wire [3:0] clk_rise = clk_now & ~clk_prev_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      clk_prev_r <= '0;
    end else begin
      clk_prev_r <= clk_now;
    end
  end

  for (genvar h = 0; h < 2; h++) begin : g_half
    localparam int IAB = 3 - 2 * h;
    localparam int IBA = 2 - 2 * h;
    wire ab_load = le_now[IAB] | clk_rise[IAB];
    wire ba_load = le_now[IBA] | clk_rise[IBA];

    // Transparent or edge-stored, else hold
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        store_ab_r[h*HALF_W +: HALF_W] <= '0;
        store_ba_r[h*HALF_W +: HALF_W] <= '0;
      end else begin
        if (ab_load) store_ab_r[h*HALF_W +: HALF_W] <= pins_now[CELL_A_LSB + h*HALF_W +: HALF_W];
        if (ba_load) store_ba_r[h*HALF_W +: HALF_W] <= pins_now[CELL_B_LSB + h*HALF_W +: HALF_W];
      end
    end

    // Active-low enables per half
    assign oe_ab_norm[h] = ~pins_now[CELL_OE_LSB + IAB];
    assign oe_ba_norm[h] = ~pins_now[CELL_OE_LSB + IBA];
  end

  // Test mode drives from cell latches; normal mode ignores the test logic
  wire [1:0] oe_ab_test = {~bsr_upd_r[CELL_OE_LSB+1], ~bsr_upd_r[CELL_OE_LSB+3]} & {2{~is_highz}};
  wire [1:0] oe_ba_test = {~bsr_upd_r[CELL_OE_LSB], ~bsr_upd_r[CELL_OE_LSB+2]} & {2{~is_highz}};
  wire [DATA_W-1:0] b_out_nxt = test_mode ? bsr_upd_r[CELL_B_LSB +: DATA_W] : store_ab_r;
  wire [DATA_W-1:0] a_out_nxt = test_mode ? bsr_upd_r[CELL_A_LSB +: DATA_W] : store_ba_r;
  wire [1:0] b_oe_nxt = test_mode ? oe_ab_test : oe_ab_norm;
  wire [1:0] a_oe_nxt = test_mode ? oe_ba_test : oe_ba_norm;

  // Pin drivers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      port_a_out <= '0;
      port_b_out <= '0;
      port_a_oe <= '0;
      port_b_oe <= '0;
    end else begin
      port_a_out <= a_out_nxt;
      port_b_out <= b_out_nxt;
      port_a_oe <= a_oe_nxt;
      port_b_oe <= b_oe_nxt;
    end
  end

  // Pin snapshots taken by the sample instruction leave through the buffer
  wire snap_push = cap_dr & is_sample;

  stbt_fifo #(
    .WIDTH(BSR_W),
    .DEPTH(SNAP_DEPTH)
  ) u_snap_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(snap_push),
    .in_ready(snap_room),
    .in_data(pins_now),
    .out_valid(snap_valid),
    .out_ready(snap_ready),
    .out_data(snap_data)
  );
endmodule // stbt_core

//--- sim/stbt_core_chk.sv
`timescale 1ns/1ps
module stbt_core_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Buses
  input wire logic [stbt_pkg::DATA_W-1:0] port_a_in,
  input wire logic [stbt_pkg::DATA_W-1:0] port_a_out,
  input wire logic [1:0] port_a_oe,
  input wire logic [stbt_pkg::DATA_W-1:0] port_b_in,
  input wire logic [stbt_pkg::DATA_W-1:0] port_b_out,
  input wire logic [1:0] port_b_oe,
  // Direction controls
  input wire logic [1:0] a_to_b_output_enable_n,
  input wire logic [1:0] b_to_a_output_enable_n,
  input wire logic [1:0] a_to_b_latch_enable,
  input wire logic [1:0] b_to_a_latch_enable,
  input wire logic [1:0] a_to_b_clock,
  // Test port, snapshots, status
  input wire logic test_clock,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  input wire logic snap_valid,
  input wire logic snap_ready,
  input wire logic [stbt_pkg::BSR_W-1:0] snap_data,
  input wire logic test_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Normal-mode data paths
  property p_ab_tr; (a_to_b_latch_enable[0] && !test_mode && $stable(port_a_in))[*6] |->
    port_b_out[8:0] == port_a_in[8:0]; endproperty
  a_ab_tr: assert property (p_ab_tr) else $error("B half 0 not following A");
  property p_ab_h1; (a_to_b_latch_enable[1] && !test_mode && $stable(port_a_in))[*6] |->
    port_b_out[17:9] == port_a_in[17:9]; endproperty
  a_ab_h1: assert property (p_ab_h1) else $error("B half 1 not following A");
  property p_ba_tr; (b_to_a_latch_enable[0] && !test_mode && $stable(port_b_in))[*6] |->
    port_a_out[8:0] == port_b_in[8:0]; endproperty
  a_ba_tr: assert property (p_ba_tr) else $error("A half 0 not following B");
  property p_ab_hold; (!a_to_b_latch_enable[0] && !test_mode && $stable(a_to_b_clock[0]))[*6] |->
    $stable(port_b_out[8:0]); endproperty
  a_ab_hold: assert property (p_ab_hold) else $error("B half 0 changed while held");
  property p_ab_store; (!a_to_b_latch_enable[0] && !test_mode && $stable(port_a_in[8:0]))[*3] ##0
    $rose(a_to_b_clock[0]) ##1 (!test_mode && $stable(port_a_in[8:0]))[*5] |->
    port_b_out[8:0] == port_a_in[8:0]; endproperty
  a_ab_store: assert property (p_ab_store) else $error("B half 0 missed clocked store");
  // Output enables
  property p_ab_oe; (!test_mode && $stable(a_to_b_output_enable_n[0]))[*4] |->
    port_b_oe[0] != a_to_b_output_enable_n[0]; endproperty
  a_ab_oe: assert property (p_ab_oe) else $error("B half 0 enable wrong");
  property p_ba_oe; (!test_mode && $stable(b_to_a_output_enable_n[1]))[*4] |->
    port_a_oe[1] != b_to_a_output_enable_n[1]; endproperty
  a_ba_oe: assert property (p_ba_oe) else $error("A half 1 enable wrong");
  // Test port timing, reset state and snapshot stall
  property p_tdo_fall; $changed(test_data_out) |-> !test_clock && $past(test_clock, 6); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("Serial out moved off a falling edge");
  property p_tdo_oe; $changed(test_data_out_oe) |-> !test_clock; endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("Serial out enable moved while clock high");
  property p_rst; $rose(reset_n) |-> !test_mode && !test_data_out_oe; endproperty
  a_rst: assert property (p_rst) else $error("Test mode active after reset");
  property p_snap; snap_valid && !snap_ready |=> snap_valid && $stable(snap_data); endproperty
  a_snap: assert property (p_snap) else $error("Snapshot word lost while stalled");
  // Main scenarios
  c_pop: cover property (snap_valid && snap_ready);
  c_tm: cover property ($rose(test_mode));
  c_store: cover property ($rose(a_to_b_clock[0]) && !a_to_b_latch_enable[0]);
endmodule // stbt_core_chk

bind stbt_core stbt_core_chk chk_u (.clock, .reset_n, .port_a_in, .port_a_out, .port_a_oe, .port_b_in,
  .port_b_out, .port_b_oe, .a_to_b_output_enable_n, .b_to_a_output_enable_n, .a_to_b_latch_enable,
  .b_to_a_latch_enable, .a_to_b_clock, .test_clock, .test_data_out, .test_data_out_oe, .snap_valid,
  .snap_ready, .snap_data, .test_mode);

//--- sim/stbt_tap_host.sv
`timescale 1ns/1ps
module stbt_tap_host (
  // Test port pins
  output logic test_clock,
  output logic test_mode_select,
  output logic test_data_in,
  input wire logic test_data_out
);
  logic tdo_s;
  // Clock stands low outside frames; serial input idles high like its pull-up
  initial begin
    test_clock = 1'b0;
    test_mode_select = 1'b1;
    test_data_in = 1'b1;
  end
  // One period: levels change while low, serial out taken at the rise
  task automatic tick(input logic tms, input logic tdi);
    test_mode_select = tms;
    test_data_in = tdi;
    #40 test_clock = 1'b1;
    tdo_s = test_data_out;
    #40 test_clock = 1'b0;
  endtask
  // Five high mode selects reach test-logic reset, then idle
  task automatic reset_tap();
    #1.5;
    repeat (5) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
  // Idle to idle scan of n bits, least significant first
  task automatic scan(input bit ir, input logic [63:0] din, input int n, output logic [63:0] dout);
    #1.5;
    dout = '0;
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(n == 0, 1'b1);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = tdo_s;
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
endmodule // stbt_tap_host

//--- sim/test_scan_test_bus_transceiver.sv
`timescale 1ns/1ps
module test_scan_test_bus_transceiver;
  import stbt_pkg::*;
  localparam logic [ID_W-1:0] ID_ARB = 32'h1357_2469; // Arbitrary value, must end in one
  logic clock, reset_n, tck, tms, tdi, tdo, tdo_oe, snap_valid, snap_ready, snap_room, tmode, tm_exp;
  logic [DATA_W-1:0] a_in, b_in, a_out, b_out, exp_b, q[$];
  logic [1:0] a_oe, b_oe, oe_ab_n, oe_ba_n, le_ab, le_ba, ck_ab, ck_ba;
  logic [BSR_W-1:0] snap_data;
  logic [IR_W-1:0] ops [8];
  logic [63:0] dout;
  logic [31:0] rng = 32'h0000_7935;
  int n_mismatch = 0;
  int checks = 0;
  int pushed;
  // Design and test controller
  stbt_core #(.ID_VALUE(ID_ARB), .SNAP_DEPTH(32)) dut_u (.clock, .reset_n, .port_a_in(a_in),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
    .a_to_b_output_enable_n(oe_ab_n), .b_to_a_output_enable_n(oe_ba_n), .a_to_b_latch_enable(le_ab),
    .b_to_a_latch_enable(le_ba), .a_to_b_clock(ck_ab), .b_to_a_clock(ck_ba), .test_clock(tck),
    .test_mode_select(tms), .test_data_in(tdi), .test_data_out(tdo), .test_data_out_oe(tdo_oe),
    .snap_valid, .snap_ready, .snap_data, .snap_room, .test_mode(tmode));
  stbt_tap_host host_u (.test_clock(tck), .test_mode_select(tms), .test_data_in(tdi), .test_data_out(tdo));
  // System clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Comparison and reporting
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic scn(input bit ir, input logic [63:0] d, input int n);
    host_u.scan(ir, d, n, dout);
    @(posedge clock);
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    a_in = '0;
    b_in = '0;
    oe_ab_n = 2'h3;
    oe_ba_n = 2'h3;
    le_ab = 2'h3;
    le_ba = 2'h3;
    ck_ab = 2'h0;
    ck_ba = 2'h0;
    snap_ready = 1'b0;
    ops = '{OP_EXTEST, OP_SAMPLE, OP_BYPASS, OP_IDCODE, OP_HIGHZ, OP_CLAMP, OP_RUNTEST, OP_READBACK};
    cyc(6);
    chk("rst_oe", {a_oe, b_oe, tdo_oe, tmode, snap_room}, 7'h01);
    reset_n <= 1'b1;
    rng = xs(rng);
    a_in <= rng[17:0];
    rng = xs(rng);
    b_in <= rng[17:0];
    oe_ab_n <= 2'h0;
    oe_ba_n <= 2'h0;
    cyc(8);
    chk("b_out", b_out, a_in);
    chk("a_out", a_out, b_in);
    chk("oe", {a_oe, b_oe}, 4'hF);
    exp_b = a_in;
    le_ab <= 2'h0;
    cyc(4);
    rng = xs(rng);
    a_in <= rng[17:0];
    cyc(8);
    chk("b_hold", b_out, exp_b);
    for (int h = 0; h < 2; h++) begin
      ck_ab[h] <= 1'b1;
      cyc(8);
      exp_b[h*9 +: 9] = a_in[h*9 +: 9];
      chk("b_store", b_out, exp_b);
    end
    oe_ab_n <= 2'h1;
    ck_ab <= 2'h0;
    cyc(6);
    chk("b_oe", b_oe, 2'h2);
    oe_ab_n <= 2'h0;
    le_ab <= 2'h3;
    host_u.reset_tap();
    scn(1'b0, '0, 32);
    chk("idcode", dout[31:0], ID_ARB);
    // Each instruction except the boundary-control scan, after a test-logic reset
    for (int k = 0; k < 8; k++) begin
      tm_exp = ops[k] inside {OP_EXTEST, OP_HIGHZ, OP_CLAMP, OP_RUNTEST};
      host_u.reset_tap();
      scn(1'b1, ops[k], 8);
      chk("ir_cap", dout[7:0], IR_CAPTURE);
      cyc(6);
      chk("test_mode", tmode, tm_exp);
      chk("oe_mode", {a_oe, b_oe}, tm_exp ? 4'h0 : 4'hF);
      if (!tm_exp) chk("b_tap", b_out, a_in);
    end
    host_u.reset_tap();
    scn(1'b1, OP_BYPASS, 8);
    scn(1'b0, 64'h0000_0000_0000_00A5, 8);
    chk("bypass", dout[7:0], 8'h4A);
    host_u.reset_tap();
    scn(1'b1, OP_SCANCTL, 8);
    scn(1'b0, '0, 3);
    chk("ctl", dout[2:0], CTL_RESET);
    // Snapshots into a stalled buffer until it refuses
    host_u.reset_tap();
    scn(1'b1, OP_SAMPLE, 8);
    pushed = 0;
    for (int k = 0; k < 34; k++) begin
      rng = xs(rng);
      a_in <= rng[17:0];
      cyc(6);
      chk("room_k", snap_room, q.size() < 32);
      if (snap_room === 1'b1) pushed++;
      if (q.size() < 32) q.push_back(a_in);
      scn(1'b0, '0, 0);
    end
    chk("pushed", pushed, 32);
    chk("room", snap_room, 1'b0);
    chk("b_snap", b_out, a_in);
    snap_ready <= 1'b1;
    for (int k = 0; k < 40 && q.size() > 0; k++) begin
      @(negedge clock);
      if (snap_valid === 1'b1) chk("snap", snap_data, {8'h00, 4'hF, b_in, q.pop_front()});
    end
    @(posedge clock);
    snap_ready <= 1'b0;
    chk("left", q.size(), 0);
    cyc(2);
    chk("empty", snap_valid, 1'b0);
    complete_run();
  end
endmodule // test_scan_test_bus_transceiver
